/* File: common/eight_bit_timer_pkg.sv */
// Constants, register map and encodings for the dual-unit 8-bit timer.
// Assumes a 32-bit APB master and a single peripheral clock.
package eight_bit_timer_pkg;
	localparam int NUM_UNITS   = 2;
	localparam int CH_PER_UNIT = 2;
	localparam int NUM_CH      = NUM_UNITS * CH_PER_UNIT;
	localparam int CNT_W       = 8;
	localparam int PRE_W       = 13;
	localparam int EV_PER_CH   = 3;
	localparam int NUM_EV      = NUM_CH * EV_PER_CH;
	localparam int ST_CMA      = 0;
	localparam int ST_CMB      = 1;
	localparam int ST_OVF      = 2;
	localparam int ADDR_W      = 8;
	localparam int DATA_W      = 32;
	localparam int CH_LSB      = 4;
	localparam int CH_IDX_W    = 2;
	localparam int ROFF_W      = 4;

	// -----------------------------------------------------------------
	// Register map
	// -----------------------------------------------------------------
	localparam logic [ROFF_W-1:0] ROFF_CTRL = 4'h0;
	localparam logic [ROFF_W-1:0] ROFF_CMPA = 4'h4;
	localparam logic [ROFF_W-1:0] ROFF_CMPB = 4'h8;
	localparam logic [ROFF_W-1:0] ROFF_CNT  = 4'hc;
	localparam logic [ADDR_W-1:0] OFF_STAT  = 8'h40;
	localparam logic [ADDR_W-1:0] OFF_MASK  = 8'h44;
	localparam logic [ADDR_W-1:0] OFF_STOP  = 8'h48;
	localparam logic [ADDR_W-1:0] OFF_EVCFG = 8'h4c;
	localparam logic [ADDR_W-1:0] OFF_LIMIT = 8'h50;

	localparam logic [CNT_W-1:0]     CNT_MAX  = 8'hff;
	localparam logic [CNT_W-1:0]     CNT_ZERO = 8'h00;
	localparam logic [CNT_W-1:0]     CMP_RST  = 8'hff;
	localparam logic [NUM_UNITS-1:0] STOP_RST = 2'h3;

	// -----------------------------------------------------------------
	// Encodings
	// -----------------------------------------------------------------
	typedef enum logic [3:0] {
		CKS_OFF = 4'h0, CKS_DIV1, CKS_DIV2, CKS_DIV8, CKS_DIV32, CKS_DIV64,
		CKS_DIV1024, CKS_DIV8192, CKS_EXT, CKS_LINK
	} cks_t;
	typedef enum logic [1:0] {CLR_NONE = 2'h0, CLR_CMA, CLR_CMB, CLR_EXT} cclr_t;
	typedef enum logic [1:0] {OUT_HOLD = 2'h0, OUT_PULSE, OUT_TOGGLE, OUT_PWM} omd_t;
	typedef enum logic [1:0] {EV_NONE = 2'h0, EV_START, EV_COUNT, EV_RESTART} evact_t;
	typedef struct packed {
		omd_t  omd;
		cclr_t cclr;
		cks_t  cks;
	} ctrl_t;
	localparam ctrl_t CTRL_RST = '{omd: OUT_HOLD, cclr: CLR_NONE, cks: CKS_OFF};

	function automatic logic [PRE_W-1:0] div_mask(input cks_t c);
		case (c)
			CKS_DIV2:    div_mask = 13'h0001;
			CKS_DIV8:    div_mask = 13'h0007;
			CKS_DIV32:   div_mask = 13'h001f;
			CKS_DIV64:   div_mask = 13'h003f;
			CKS_DIV1024: div_mask = 13'h03ff;
			CKS_DIV8192: div_mask = 13'h1fff;
			default:     div_mask = 13'h0000;
		endcase
	endfunction
endpackage

/* File: rtl/eight_bit_timer.sv */
// Two timer units, each with two 8-bit channels, behind an APB slave.
// Assumes pins are synchronous to CLK_SYS and single-cycle event inputs.
// How it works
// RL1: Each channel counts prescaled clock /1,/2,/8,/32,/64,/1024,/8192 or an external clock.
// RL2: There are two units of two channels, each with an 8-bit counter.
// RL3: Each channel compares against A and B, and a cascaded pair compares at 16 bits.
// RL4: The counter clears on match A, match B or the external reset input, as selected.
// RL5: Each channel drives a timer output as a duty-cycle pulse, a toggle or a PWM wave.
// RL6: In 16-bit mode the even channel is the upper byte and the odd channel the lower.
// RL7: In match count mode the odd channel counts match A events of the even channel.
// RL8: Each channel raises separate requests for match A, match B and overflow.
// RL9: Only even channels drive link outputs for match A, match B and overflow.
// RL10: An accepted link input starts, clocks or restarts the even channel of the unit.
// RL11: Match A and match B pulses serve as transfer controller triggers.
// RL12: The unit's odd-channel output serves as the serial channel baud clock.
// RL13: The output of channel 0 serves as the remote control receiver clock.
// RL14: Each unit can be stopped on its own, freezing its counters and events.
// RL15: A match is flagged in the first cycle the counter equals the compare value.
// RL16: Overflow is flagged when the counter wraps from all ones, at 16 bits in cascade.
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module eight_bit_timer
	import eight_bit_timer_pkg::*;
(
	input  wire logic                           CLK_SYS,
	input  wire logic                           SRST,
	input  wire logic                           PSEL,
	input  wire logic                           PENABLE,
	input  wire logic                           PWRITE,
	input  wire logic [ADDR_W-1:0]              PADDR,
	input  wire logic [DATA_W-1:0]              PWDATA,
	output logic      [DATA_W-1:0]              PRDATA,
	output logic                                PREADY,
	output logic                                PSLVERR,
	input  wire logic [NUM_CH-1:0]              EXT_CLK,
	input  wire logic [NUM_CH-1:0]              EXT_RST,
	input  wire logic [NUM_UNITS-1:0]           LINK_EVT_IN,
	output logic      [NUM_CH-1:0]              TIMER_OUT,
	output logic      [NUM_UNITS*EV_PER_CH-1:0] LINK_EVT_OUT,
	output logic      [NUM_EV-1:0]              IRQ_REQ,
	output logic                                IRQ,
	output logic      [2*NUM_CH-1:0]            XFER_TRIG,
	output logic      [NUM_UNITS-1:0]           BAUD_CLK,
	output logic                                RCV_CLK
);
	// -----------------------------------------------------------------
	// Bus decode
	// -----------------------------------------------------------------
	logic                access;
	logic                wr;
	logic                mapped;
	logic                glob;
	logic [CH_IDX_W-1:0] sel_ch;
	logic [ROFF_W-1:0]   roff;

	assign access  = PSEL & PENABLE;
	assign mapped  = ~|PADDR[1:0] && (PADDR < OFF_LIMIT);
	assign wr      = access & PWRITE & mapped;
	assign glob    = PADDR >= OFF_STAT;
	assign sel_ch  = PADDR[CH_LSB +: CH_IDX_W];
	assign roff    = PADDR[ROFF_W-1:0];
	assign PREADY  = 1'b1;
	assign PSLVERR = access & ~mapped;

	// -----------------------------------------------------------------
	// Registers
	// -----------------------------------------------------------------
	ctrl_t                ctrl_ff [NUM_CH];
	logic [CNT_W-1:0]     cmpa_ff [NUM_CH];
	logic [CNT_W-1:0]     cmpb_ff [NUM_CH];
	evact_t               evact_ff [NUM_UNITS];
	logic [NUM_EV-1:0]    status_ff;
	logic [NUM_EV-1:0]    mask_ff;
	logic [NUM_EV-1:0]    evt_ff;
	logic [NUM_EV-1:0]    evt_w;
	logic [NUM_EV-1:0]    w1c;
	logic [NUM_UNITS-1:0] stop_ff;
	logic [NUM_UNITS-1:0] started_ff;
	logic [DATA_W-1:0]    prdata_ff;
	logic [DATA_W-1:0]    rdata;
	logic [PRE_W-1:0]     pre_ff;
	logic [NUM_CH-1:0][CNT_W-1:0] cnt_w;

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			for (int i = 0; i < NUM_CH; i++) begin
				ctrl_ff[i] <= CTRL_RST;
				cmpa_ff[i] <= CMP_RST;
				cmpb_ff[i] <= CMP_RST;
			end
		end else if (wr && !glob) begin
			case (roff)
				ROFF_CTRL: ctrl_ff[sel_ch] <= ctrl_t'(PWDATA[CNT_W-1:0]);
				ROFF_CMPA: cmpa_ff[sel_ch] <= PWDATA[CNT_W-1:0];
				ROFF_CMPB: cmpb_ff[sel_ch] <= PWDATA[CNT_W-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			mask_ff <= '0;
			stop_ff <= STOP_RST;
			for (int u = 0; u < NUM_UNITS; u++) begin
				evact_ff[u] <= EV_NONE;
			end
		end else if (wr) begin
			case (PADDR)
				OFF_MASK: mask_ff <= PWDATA[NUM_EV-1:0];
				OFF_STOP: stop_ff <= PWDATA[NUM_UNITS-1:0]; // [RL14]
				OFF_EVCFG: begin
					for (int u = 0; u < NUM_UNITS; u++) begin
						evact_ff[u] <= evact_t'(PWDATA[2*u +: 2]);
					end
				end
				default: ;
			endcase
		end
	end

	// Event set wins over a same-cycle write-one-to-clear
	assign w1c = (wr && PADDR == OFF_STAT) ? PWDATA[NUM_EV-1:0] : '0;

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			status_ff <= '0;
			evt_ff    <= '0;
		end else begin
			evt_ff    <= evt_w;
			status_ff <= (status_ff & ~w1c) | evt_ff; // [RL8]
		end
	end

	always_comb begin
		rdata = '0;
		if (glob) begin
			case (PADDR)
				OFF_STAT:  rdata[NUM_EV-1:0] = status_ff;
				OFF_MASK:  rdata[NUM_EV-1:0] = mask_ff;
				OFF_STOP:  rdata[NUM_UNITS-1:0] = stop_ff;
				OFF_EVCFG: begin
					for (int u = 0; u < NUM_UNITS; u++) begin
						rdata[2*u +: 2] = evact_ff[u];
					end
				end
				default: ;
			endcase
		end else begin
			case (roff)
				ROFF_CTRL: rdata[CNT_W-1:0] = ctrl_ff[sel_ch];
				ROFF_CMPA: rdata[CNT_W-1:0] = cmpa_ff[sel_ch];
				ROFF_CMPB: rdata[CNT_W-1:0] = cmpb_ff[sel_ch];
				ROFF_CNT:  rdata[CNT_W-1:0] = cnt_w[sel_ch];
				default: ;
			endcase
		end
	end

	// Read data is captured in the setup cycle so the access phase needs no wait
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			prdata_ff <= '0;
		end else if (PSEL && !PENABLE && !PWRITE) begin
			prdata_ff <= rdata;
		end
	end
	assign PRDATA = prdata_ff;

	// -----------------------------------------------------------------
	// Prescaler
	// -----------------------------------------------------------------
	// Shared free-running divider; a channel's first tick may come early
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			pre_ff <= '0;
		end else begin
			pre_ff <= pre_ff + 13'h0001;
		end
	end

	// -----------------------------------------------------------------
	// Units
	// -----------------------------------------------------------------
	logic [NUM_CH-1:0]            tick_w;
	logic [NUM_CH-1:0]            wrap_w;
	logic [NUM_CH-1:0]            cma_w;
	logic [NUM_CH-1:0]            upd_w;
	logic [NUM_CH-1:0]            tmo_w;
	logic [NUM_UNITS-1:0]         c16_w;
	logic [NUM_UNITS-1:0]         eqa16_w;
	logic [NUM_UNITS-1:0]         eqb16_w;
	logic [NUM_UNITS-1:0]         link_acc_w;
	logic [NUM_UNITS-1:0]         run_w;

	for (genvar u = 0; u < NUM_UNITS; u++) begin : gen_unit
		localparam int EV = u * CH_PER_UNIT;
		assign c16_w[u]      = ctrl_ff[EV].cks == CKS_LINK; // [RL6]
		assign eqa16_w[u]    = {cnt_w[EV], cnt_w[EV+1]} == {cmpa_ff[EV], cmpa_ff[EV+1]}; // [RL3]
		assign eqb16_w[u]    = {cnt_w[EV], cnt_w[EV+1]} == {cmpb_ff[EV], cmpb_ff[EV+1]}; // [RL3]
		assign link_acc_w[u] = LINK_EVT_IN[u] & ~stop_ff[u];
		assign run_w[u]      = (evact_ff[u] != EV_START) || started_ff[u];
		assign LINK_EVT_OUT[u*EV_PER_CH +: EV_PER_CH] = evt_ff[EV*EV_PER_CH +: EV_PER_CH]; // [RL9]
		assign BAUD_CLK[u]   = tmo_w[EV+1]; // [RL12]

		always_ff @(posedge CLK_SYS) begin
			if (SRST) begin
				started_ff[u] <= 1'b0;
			end else if (wr && PADDR == OFF_EVCFG) begin
				started_ff[u] <= 1'b0;
			end else if (link_acc_w[u] && evact_ff[u] == EV_START) begin
				started_ff[u] <= 1'b1; // [RL10]
			end
		end
	end

	// -----------------------------------------------------------------
	// Channels
	// -----------------------------------------------------------------
	for (genvar ch = 0; ch < NUM_CH; ch++) begin : gen_ch
		localparam int U       = ch / CH_PER_UNIT;
		localparam int EV      = U * CH_PER_UNIT;
		localparam int OD      = EV + 1;
		localparam bit IS_EVEN = (ch % CH_PER_UNIT) == 0;
		logic [CNT_W-1:0] cnt_ff;
		logic [CNT_W-1:0] nxt_cnt;
		logic             upd_ff;
		logic             ext_d_ff;
		logic             tmo_ff;
		logic             nxt_tmo;
		logic             partner_evt;
		logic             tick_src;
		logic             tick;
		logic             tclr;
		logic             gang;
		logic             eqa;
		logic             eqb;
		logic             own_eqa;
		logic             own_eqb;
		logic             mclr;
		logic             clr_now;
		logic             restart;
		logic             wr_cnt;
		logic             cma;
		logic             cmb;
		logic             evt_upd;
		ctrl_t            cfg;

		assign partner_evt = IS_EVEN ? wrap_w[OD] : cma_w[EV]; // [RL6] [RL7]

		always_comb begin
			case (ctrl_ff[ch].cks)
				CKS_OFF:  tick_src = 1'b0;
				CKS_EXT:  tick_src = EXT_CLK[ch] & ~ext_d_ff; // [RL1]
				CKS_LINK: tick_src = partner_evt;
				default:  tick_src = (pre_ff & div_mask(ctrl_ff[ch].cks))
				                     == div_mask(ctrl_ff[ch].cks); // [RL1]
			endcase
			if (IS_EVEN && evact_ff[U] == EV_COUNT) begin
				tick_src = link_acc_w[U]; // [RL10]
			end
		end

		assign gang    = c16_w[U];
		assign cfg     = gang ? ctrl_ff[EV] : ctrl_ff[ch];
		assign tick    = tick_src & ~stop_ff[U] & (run_w[U] | ~(IS_EVEN | gang)); // [RL14]
		assign tclr    = gang ? tick_w[OD] : tick;
		assign own_eqa = cnt_ff == cmpa_ff[ch];
		assign own_eqb = cnt_ff == cmpb_ff[ch];
		assign eqa     = gang ? eqa16_w[U] : own_eqa;
		assign eqb     = gang ? eqb16_w[U] : own_eqb;
		assign restart = link_acc_w[U] & (evact_ff[U] == EV_RESTART) & (IS_EVEN | gang);
		assign mclr    = tclr & ((cfg.cclr == CLR_CMA & eqa) | (cfg.cclr == CLR_CMB & eqb)); // [RL4]
		assign clr_now = ~stop_ff[U] & ((cfg.cclr == CLR_EXT & EXT_RST[gang ? EV : ch])
		                 | restart); // [RL4] [RL10]
		assign wr_cnt  = wr & ~glob & (sel_ch == CH_IDX_W'(ch)) & (roff == ROFF_CNT);
		assign wrap_w[ch] = tick & (cnt_ff == CNT_MAX) & ~mclr & ~clr_now & ~wr_cnt; // [RL16]

		// A 16-bit match on the upper channel can follow either byte moving
		assign evt_upd = upd_ff | (IS_EVEN & gang & upd_w[OD]);
		assign cma     = evt_upd & ((IS_EVEN & gang) ? eqa16_w[U] : own_eqa); // [RL15]
		assign cmb     = evt_upd & ((IS_EVEN & gang) ? eqb16_w[U] : own_eqb); // [RL15]

		assign nxt_cnt = wr_cnt ? PWDATA[CNT_W-1:0]
		               : (clr_now || mclr) ? CNT_ZERO
		               : tick ? cnt_ff + 8'h01 : cnt_ff; // [RL2]

		always_comb begin
			nxt_tmo = tmo_ff;
			case (ctrl_ff[ch].omd)
				OUT_PULSE:  nxt_tmo = cmb ? 1'b0 : (cma ? 1'b1 : tmo_ff); // [RL5]
				OUT_TOGGLE: nxt_tmo = cma ? ~tmo_ff : tmo_ff; // [RL5]
				OUT_PWM:    nxt_tmo = cma ? 1'b0
				                      : (mclr || clr_now || wrap_w[ch]) ? 1'b1 : tmo_ff; // [RL5]
				default: ;
			endcase
		end

		always_ff @(posedge CLK_SYS) begin
			if (SRST) begin
				cnt_ff   <= CNT_ZERO;
				upd_ff   <= 1'b0;
				ext_d_ff <= 1'b0;
				tmo_ff   <= 1'b0;
			end else begin
				cnt_ff   <= nxt_cnt;
				upd_ff   <= tick | mclr;
				ext_d_ff <= EXT_CLK[ch];
				tmo_ff   <= nxt_tmo;
			end
		end

		assign cnt_w[ch]  = cnt_ff;
		assign tick_w[ch] = tick;
		assign cma_w[ch]  = cma;
		assign upd_w[ch]  = upd_ff;
		assign tmo_w[ch]  = tmo_ff;
		assign evt_w[ch*EV_PER_CH + ST_CMA] = cma; // [RL8]
		assign evt_w[ch*EV_PER_CH + ST_CMB] = cmb; // [RL8]
		assign evt_w[ch*EV_PER_CH + ST_OVF] = wrap_w[ch]; // [RL8]
		assign XFER_TRIG[2*ch]     = evt_ff[ch*EV_PER_CH + ST_CMA]; // [RL11]
		assign XFER_TRIG[2*ch + 1] = evt_ff[ch*EV_PER_CH + ST_CMB]; // [RL11]
		assign TIMER_OUT[ch]       = tmo_ff;
	end

	assign IRQ_REQ = status_ff & mask_ff;
	assign IRQ     = |IRQ_REQ;
	assign RCV_CLK = tmo_w[0]; // [RL13]

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (SRST);

	AST_DIV8_SPACING: assert property ( // [RL1]
		ctrl_ff[0].cks == CKS_DIV8 && gen_ch[0].tick_src
		|=> (!gen_ch[0].tick_src || ctrl_ff[0].cks != CKS_DIV8) [*7]
		##1 (gen_ch[0].tick_src || ctrl_ff[0].cks != CKS_DIV8))
		else $error("divide-by-8 tick spacing wrong");
	AST_MATCH_EQ: assert property ( // [RL15]
		cma_w[1] |-> cnt_w[1] == cmpa_ff[1] && $past(cnt_w[1]) != cnt_w[1] || $past(upd_w[1]))
		else $error("match A without equal count");
	AST_MATCH_TO_STATUS: assert property ( // [RL8]
		cma_w[1] |=> evt_ff[EV_PER_CH + ST_CMA] ##1 status_ff[EV_PER_CH + ST_CMA])
		else $error("match A did not reach status");
	AST_IRQ_RAISE: assert property ( // [RL8]
		evt_ff[ST_OVF] && mask_ff[ST_OVF] |=> IRQ)
		else $error("unmasked event did not raise interrupt");
	AST_CASCADE_CARRY: assert property ( // [RL6]
		c16_w[0] && evact_ff[0] != EV_COUNT && wrap_w[1] |-> tick_w[0])
		else $error("lower byte wrap did not carry");
	AST_MATCH_COUNT: assert property ( // [RL7]
		ctrl_ff[1].cks == CKS_LINK && !c16_w[0] && cma_w[0] && !stop_ff[0] |-> tick_w[1])
		else $error("odd channel missed a match count");
	AST_OVF16_FULL: assert property ( // [RL16]
		c16_w[0] && wrap_w[0] |-> cnt_w[0] == CNT_MAX && cnt_w[1] == CNT_MAX)
		else $error("16-bit overflow before full scale");
	AST_CLEAR_ON_A: assert property ( // [RL4]
		!c16_w[0] && ctrl_ff[1].cclr == CLR_CMA && tick_w[1] && cnt_w[1] == cmpa_ff[1]
		&& !gen_ch[1].wr_cnt |=> cnt_w[1] == CNT_ZERO)
		else $error("count not cleared on match A");
	AST_STOP_FREEZE: assert property ( // [RL14]
		stop_ff[1] && !gen_ch[2].wr_cnt |=> cnt_w[2] == $past(cnt_w[2]))
		else $error("stopped unit counter moved");
	AST_LINK_OUT: assert property ( // [RL9]
		evt_w[NUM_EV/NUM_UNITS + ST_CMB] |=> LINK_EVT_OUT[EV_PER_CH + ST_CMB])
		else $error("even channel link output missing");
endmodule

/* File: test/link_model.sv */
// Model of the event link fabric and timer pins facing the timer.
// Assumes one bench process calls its tasks, all on CLK_SYS.
`timescale 1ns/1ps
module link_model (
	input  wire logic       clk,
	output logic [3:0]      ext_clk,
	output logic [1:0]      link_in,
	input  wire logic [5:0] evt_out,
	input  wire logic [7:0] trig
);
	int ev_cnt [6];
	int tr_cnt [8];
	int cyc;
	int last;
	int gap;

	initial begin
		ext_clk = '0;
		link_in = '0;
	end

	// Pulse counters; only a clean high counts, so an unknown never passes
	always @(posedge clk) begin
		cyc++;
		// Gap is settled before the count that wakes a waiting caller moves
		if (trig[0] === 1'b1) begin
			gap = cyc - last;
			last = cyc;
		end
		for (int i = 0; i < 8; i++) begin
			if (i < 6 && evt_out[i] === 1'b1)
				ev_cnt[i]++;
			if (trig[i] === 1'b1)
				tr_cnt[i]++;
		end
	end

	task automatic clr();
		ev_cnt = '{default: 0};
		tr_cnt = '{default: 0};
	endtask

	// Count clock idles low between pulses, as a real pin would
	task automatic edges(input int ch, input int n);
		repeat (n) begin
			@(posedge clk) ext_clk[ch] <= 1'b1;
			repeat (2) @(posedge clk);
			ext_clk[ch] <= 1'b0;
			repeat (2) @(posedge clk);
		end
	endtask

	task automatic pulse(input int u);
		@(posedge clk) link_in[u] <= 1'b1;
		@(posedge clk) link_in[u] <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	// Third pulse after the call: the first gap may follow a mode change
	task automatic gap_of(output int g);
		int s;
		s = tr_cnt[0];
		wait (tr_cnt[0] >= s + 3);
		g = gap;
	endtask
endmodule

/* File: test/tb.sv */
// Self-checking bench for the dual-unit 8-bit timer.
// Assumes the register map of the timer package and an APB that ends each access on PREADY.
`timescale 1ns/1ps
`define CHK(g, e) begin \
	checked++; \
	if ((g) !== (e)) begin \
		n_mismatch++; \
		$display("[FAIL] %0t got %0h exp %0h", $time, g, e); \
	end \
end
module tb
	import eight_bit_timer_pkg::*;
;
	logic              CLK_SYS = 1'b0;
	logic              SRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ, RCV_CLK;
	logic [ADDR_W-1:0] PADDR;
	logic [DATA_W-1:0] PWDATA, PRDATA;
	logic [3:0]        EXT_CLK, EXT_RST, TIMER_OUT;
	logic [1:0]        LINK_EVT_IN, BAUD_CLK;
	logic [5:0]        LINK_EVT_OUT;
	logic [11:0]       IRQ_REQ;
	logic [7:0]        XFER_TRIG;
	int                n_mismatch, checked;
	int                seed = 8;
	int                dv [7] = '{1, 2, 8, 32, 64, 1024, 8192};
	typedef struct {logic [DATA_W-1:0] d; logic e;} note_t;
	note_t             exp_q [$];

	always #2.5 CLK_SYS = ~CLK_SYS;

	eight_bit_timer dut (.CLK_SYS(CLK_SYS), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .EXT_CLK(EXT_CLK), .EXT_RST(EXT_RST), .LINK_EVT_IN(LINK_EVT_IN),
		.TIMER_OUT(TIMER_OUT), .LINK_EVT_OUT(LINK_EVT_OUT), .IRQ_REQ(IRQ_REQ), .IRQ(IRQ),
		.XFER_TRIG(XFER_TRIG), .BAUD_CLK(BAUD_CLK), .RCV_CLK(RCV_CLK));

	link_model fab (.clk(CLK_SYS), .ext_clk(EXT_CLK), .link_in(LINK_EVT_IN),
		.evt_out(LINK_EVT_OUT), .trig(XFER_TRIG));

	// ---------------------------------------------------------------
	// Bus tasks
	// ---------------------------------------------------------------
	function automatic logic [ADDR_W-1:0] ra(input int ch, input logic [ROFF_W-1:0] r);
		return ADDR_W'(ch << CH_LSB) | ADDR_W'(r);
	endfunction

	function automatic logic [DATA_W-1:0] cw(input omd_t o, input cclr_t c, input cks_t k);
		ctrl_t t;
		t = '{omd: o, cclr: c, cks: k};
		return DATA_W'(t);
	endfunction

	// No wait count is assumed: the access edge is the one with PREADY high
	task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge CLK_SYS);
		PSEL    <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE  <= w;
		PADDR   <= a;
		PWDATA  <= d;
		@(posedge CLK_SYS);
		PENABLE <= 1'b1;
		do @(posedge CLK_SYS); while (PREADY !== 1'b1);
		PSEL    <= 1'b0;
		PENABLE <= 1'b0;
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic e);
		exp_q.push_back('{d, e});
		xfer(1'b0, a, '0);
	endtask

	always @(posedge CLK_SYS) begin
		if (PSEL && PENABLE && !PWRITE && PREADY === 1'b1) begin
			`CHK({PSLVERR, PRDATA}, {exp_q[0].e, exp_q[0].d})
			void'(exp_q.pop_front());
		end
	end

	task automatic finish_test();
		if (n_mismatch == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		#400_000;
		n_mismatch++;
		finish_test();
	end

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	initial begin
		int p, h0, h1, h2, h3, h4;
		logic [DATA_W-1:0] r;
		SRST = 1'b1;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = '0;
		PWDATA = '0;
		EXT_RST = '0;
		repeat (6) @(posedge CLK_SYS);
		SRST <= 1'b0;
		rd(ra(0, ROFF_CTRL), 32'h0, 1'b0);
		rd(ra(1, ROFF_CMPA), 32'hff, 1'b0);
		rd(OFF_STOP, 32'h3, 1'b0);
		rd(OFF_LIMIT, 32'h0, 1'b1);
		rd(8'h42, 32'h0, 1'b1);
		`CHK(IRQ, 1'b0)
		wr(ra(3, ROFF_CTRL), cw(OUT_HOLD, CLR_EXT, CKS_EXT));
		fab.edges(3, 2);
		rd(ra(3, ROFF_CNT), 32'h0, 1'b0);
		wr(OFF_STOP, 32'h0);
		fab.edges(3, 2);
		rd(ra(3, ROFF_CNT), 32'h2, 1'b0);
		@(posedge CLK_SYS) EXT_RST[3] <= 1'b1;
		@(posedge CLK_SYS) EXT_RST[3] <= 1'b0;
		rd(ra(3, ROFF_CNT), 32'h0, 1'b0);
		r = $random(seed);
		wr(ra(3, ROFF_CMPB), r);
		rd(ra(3, ROFF_CMPB), {24'h0, r[7:0]}, 1'b0);
		wr(ra(0, ROFF_CMPA), 32'h2);
		wr(ra(0, ROFF_CTRL), cw(OUT_HOLD, CLR_CMA, CKS_EXT));
		wr(ra(1, ROFF_CTRL), cw(OUT_HOLD, CLR_NONE, CKS_LINK));
		fab.clr();
		fab.edges(0, 9);
		rd(ra(0, ROFF_CNT), 32'h0, 1'b0);
		rd(ra(1, ROFF_CNT), 32'h3, 1'b0);
		`CHK(fab.tr_cnt[0], 3)
		`CHK(fab.ev_cnt[0], 3)
		wr(ra(0, ROFF_CTRL), cw(OUT_HOLD, CLR_NONE, CKS_LINK));
		wr(ra(1, ROFF_CTRL), cw(OUT_HOLD, CLR_NONE, CKS_EXT));
		wr(ra(1, ROFF_CNT), 32'hfd);
		fab.edges(1, 5);
		rd(ra(0, ROFF_CNT), 32'h1, 1'b0);
		rd(ra(1, ROFF_CNT), 32'h2, 1'b0);
		wr(ra(0, ROFF_CTRL), cw(OUT_HOLD, CLR_NONE, CKS_EXT));
		wr(ra(0, ROFF_CNT), 32'h0);
		wr(ra(2, ROFF_CTRL), cw(OUT_HOLD, CLR_NONE, CKS_EXT));
		wr(OFF_EVCFG, 32'hd);
		fab.edges(0, 2);
		rd(ra(0, ROFF_CNT), 32'h0, 1'b0);
		fab.pulse(0);
		fab.edges(0, 2);
		rd(ra(0, ROFF_CNT), 32'h2, 1'b0);
		fab.edges(2, 3);
		rd(ra(2, ROFF_CNT), 32'h3, 1'b0);
		fab.pulse(1);
		rd(ra(2, ROFF_CNT), 32'h0, 1'b0);
		wr(OFF_EVCFG, 32'h8);
		repeat (3) fab.pulse(1);
		rd(ra(2, ROFF_CNT), 32'h3, 1'b0);
		wr(OFF_EVCFG, 32'h0);
		wr(ra(0, ROFF_CMPA), 32'h1);
		wr(ra(0, ROFF_CNT), 32'h0);
		for (int i = 0; i < 7; i++) begin
			wr(ra(0, ROFF_CTRL), cw(OUT_HOLD, CLR_CMA, cks_t'(int'(CKS_DIV1) + i)));
			fab.gap_of(p);
			`CHK(p, 2 * dv[i])
		end
		wr(ra(0, ROFF_CMPB), 32'h3);
		wr(ra(0, ROFF_CTRL), cw(OUT_PWM, CLR_CMB, CKS_DIV1));
		wr(ra(1, ROFF_CMPA), 32'h1);
		wr(ra(1, ROFF_CTRL), cw(OUT_TOGGLE, CLR_CMA, CKS_DIV1));
		wr(ra(3, ROFF_CMPA), 32'h1);
		wr(ra(3, ROFF_CMPB), 32'h3);
		wr(ra(3, ROFF_CTRL), cw(OUT_PULSE, CLR_CMB, CKS_DIV1));
		repeat (300) @(posedge CLK_SYS);
		repeat (40) begin
			@(posedge CLK_SYS);
			h0 += int'(TIMER_OUT[0] === 1'b1);
			h1 += int'(RCV_CLK === 1'b1);
			h2 += int'(TIMER_OUT[1] === 1'b1);
			h3 += int'(BAUD_CLK[0] === 1'b1);
			h4 += int'(TIMER_OUT[3] === 1'b1);
		end
		`CHK(h0, 20)
		`CHK(h1, 20)
		`CHK(h2, 20)
		`CHK(h3, 20)
		`CHK(h4, 20)
		wr(ra(3, ROFF_CTRL), cw(OUT_HOLD, CLR_NONE, CKS_OFF));
		wr(OFF_STOP, 32'h1);
		repeat (4) @(posedge CLK_SYS);
		wr(OFF_STAT, 32'hfff);
		fab.clr();
		rd(OFF_STAT, 32'h0, 1'b0);
		wr(ra(2, ROFF_CNT), 32'hfe);
		wr(OFF_MASK, 32'h100);
		fab.edges(2, 2);
		rd(OFF_STAT, 32'h1c0, 1'b0);
		`CHK(IRQ_REQ, 12'h100)
		`CHK(IRQ, 1'b1)
		`CHK(fab.ev_cnt[3] + fab.ev_cnt[4] + fab.ev_cnt[5], 3)
		`CHK(fab.tr_cnt[4] + fab.tr_cnt[5], 2)
		wr(OFF_MASK, 32'h0);
		repeat (2) @(posedge CLK_SYS);
		`CHK(IRQ, 1'b0)
		wr(OFF_MASK, 32'h100);
		wr(OFF_STAT, 32'h100);
		repeat (2) @(posedge CLK_SYS);
		`CHK(IRQ, 1'b0)
		rd(OFF_STAT, 32'hc0, 1'b0);
		@(posedge CLK_SYS);
		finish_test();
	end
endmodule
